/* logic/clock_source_monitor_status.sv */
// monitor control, fine trim and status registers of the clock generator
`timescale 1ns/10ps
`include "clock_source_defines.svh"

// Notes on behaviour
// RULE_01 - with the external monitor enabled a lost external clock raises a reset request, otherwise nothing.
// RULE_02 - software enables the external monitor only in a mode that runs from the external clock.
// RULE_03 - bits 4 to 1 of the trim register and bit 5 of status ignore writes and read zero.
// RULE_04 - the fine trim bit lengthens the slow reference period when set and shortens it when clear.
// RULE_05 - outside debug the fine trim bit is loaded from a factory value during reset; the code loads it on the first clock after reset is released.
// RULE_06 - the loss of lock flag sets when detection is on and the loop leaves tolerance after locking.
// RULE_07 - the loss of lock flag clears on reset or on a written one and ignores a written zero.
// RULE_08 - a set loss of lock flag requests an interrupt only when its enable is set.
// RULE_09 - the lock bit shows the loop lock and is held clear while the loop is disabled.
// RULE_10 - a change of reference select, divider or coarse trim in internal modes clears lock until relock.
// RULE_11 - stop mode entry clears lock until the loop locks again.
// RULE_12 - the reference source status follows the select only after synchronisation.
// RULE_13 - the reference source status reads 0 for external and 1 for internal.
// RULE_14 - the mode status reads 00 loop, 01 internal bypass, 10 external bypass, after synchronisation.
// RULE_15 - the loss of lock enable gives no request at 0 and a request on loss of lock at 1.
// RULE_16 - the loss of lock request is a level held while flag and enable are both set.
module clock_source_monitor_status
  import clock_source_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  // clock and reset
  input  wire logic              mclk_i,
  input  wire logic              resetn_i,
  // register port
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic      [DATA_W-1:0] rdata_o,
  // factory trim and debug
  input  wire logic              debug_active_i,
  input  wire logic              factory_fine_trim_i,
  // loop and generator state
  input  wire logic              loop_enabled_i,
  input  wire logic              loop_in_tolerance_i,
  input  wire logic              lock_detect_en_i,
  input  wire logic              ref_source_select_i,
  input  wire logic [2:0]        ref_divider_i,
  input  wire logic [7:0]        slow_ref_coarse_trim_i,
  input  wire logic [1:0]        clock_mode_select_i,
  input  wire logic              stop_entry_i,
  input  wire logic              ext_clock_lost_i,
  // outputs
  output logic                   slow_ref_fine_trim_o,
  output logic                   ext_clock_monitor_enable_o,
  output logic                   clock_reset_req_o,
  output logic                   loss_of_lock_irq_o,
  output logic                   irq_o
);

  // ---------------------------------------------------------------
  // parameter check
  // ---------------------------------------------------------------
  if (DATA_W != 8 || ADDR_W < 16) begin : g_bad_param
    $error("clock_source_monitor_status needs DATA_W 8 and ADDR_W of at least 16");
  end

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic                      loss_of_lock_irq_enable_ff;
  logic                      ext_clock_monitor_enable_ff;
  logic                      slow_ref_fine_trim_ff;
  logic                      loss_of_lock_flag_ff;
  lock_state_t               lock_state_ff;
  lock_state_t               nxt_lock_state;
  logic                      ref_sel_ff;
  logic [2:0]                div_ff;
  logic [7:0]                coarse_ff;
  logic [`IRQ_SRC_NUM-1:0]   irq_status_ff;
  logic [`IRQ_SRC_NUM-1:0]   irq_enable_ff;
  logic [DATA_W-1:0]         rdata_ff;
  logic                      reset_req_ff;
  logic                      in_reset_ff;

  status_sync_if sif ();

  // ---------------------------------------------------------------
  // synchronised status report
  // ---------------------------------------------------------------
  assign sif.ref_src_raw = ref_source_select_i;
  assign sif.mode_raw    = clock_mode_select_i;

  status_sync u_status_sync (
    .mclk_i   (mclk_i),
    .resetn_i (resetn_i),
    .sif      (sif)
  );

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] off);
    hit = (a == ADDR_W'(off));
  endfunction : hit

  wire wr_trim    = wr_i && hit(addr_i, `ADDR_MON_TRIM);
  wire wr_status  = wr_i && hit(addr_i, `ADDR_STATUS);
  wire wr_irq_en  = wr_i && hit(addr_i, `ADDR_IRQ_ENABLE);
  wire wr_irq_clr = wr_i && hit(addr_i, `ADDR_IRQ_CLEAR);

  // ---------------------------------------------------------------
  // lock tracking
  // ---------------------------------------------------------------
  wire internal_mode = (clock_mode_select_i != MODE_BYP_EXT) && ref_source_select_i;
  wire setting_change = (ref_sel_ff != ref_source_select_i)
                     || (div_ff != ref_divider_i)
                     || (internal_mode && (coarse_ff != slow_ref_coarse_trim_i));
  wire lock_now  = (lock_state_ff == LOCK_HELD);
  wire lose_lock = lock_now && lock_detect_en_i && !loop_in_tolerance_i;

  always_comb begin
    nxt_lock_state = lock_state_ff;
    case (lock_state_ff)
      LOCK_OFF: begin
        if (loop_enabled_i && !stop_entry_i) begin
          nxt_lock_state = LOCK_SEEK;
        end
      end
      LOCK_SEEK: begin
        if (loop_in_tolerance_i && lock_detect_en_i) begin
          nxt_lock_state = LOCK_HELD;
        end
      end
      LOCK_HELD: begin
        if (setting_change || !loop_in_tolerance_i) begin // [RULE_10]
          nxt_lock_state = LOCK_SEEK;
        end
      end
      default: begin
        nxt_lock_state = LOCK_OFF;
      end
    endcase
    if (!loop_enabled_i || stop_entry_i || !lock_detect_en_i) begin // [RULE_09] [RULE_11]
      nxt_lock_state = LOCK_OFF;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      lock_state_ff <= LOCK_OFF;
      ref_sel_ff    <= `RST_REF_SRC;
      div_ff        <= 3'h0;
      coarse_ff     <= 8'h00;
    end else begin
      lock_state_ff <= nxt_lock_state;
      ref_sel_ff    <= ref_source_select_i;
      div_ff        <= ref_divider_i;
      coarse_ff     <= slow_ref_coarse_trim_i;
    end
  end

  // ---------------------------------------------------------------
  // loss of lock flag
  // ---------------------------------------------------------------
  wire lol_clear = wr_status && wdata_i[`BIT_LOL_FLAG] && loss_of_lock_flag_ff;

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      loss_of_lock_flag_ff <= 1'b0; // [RULE_07]
    end else if (lose_lock) begin
      loss_of_lock_flag_ff <= 1'b1; // [RULE_06]
    end else if (lol_clear) begin
      loss_of_lock_flag_ff <= 1'b0; // [RULE_07]
    end
  end

  // ---------------------------------------------------------------
  // monitor and trim control
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    in_reset_ff <= !resetn_i;
    if (!resetn_i) begin
      loss_of_lock_irq_enable_ff  <= 1'b0;
      ext_clock_monitor_enable_ff <= 1'b0;
      slow_ref_fine_trim_ff       <= 1'b0;
    end else if (wr_trim) begin // [RULE_03]
      loss_of_lock_irq_enable_ff  <= wdata_i[`BIT_LOL_IRQ_EN];
      ext_clock_monitor_enable_ff <= wdata_i[`BIT_EXT_MON_EN];
      slow_ref_fine_trim_ff       <= wdata_i[`BIT_FINE_TRIM]; // [RULE_04]
    end else if (in_reset_ff && !debug_active_i) begin
      slow_ref_fine_trim_ff       <= factory_fine_trim_i; // [RULE_05]
    end
  end

  // ---------------------------------------------------------------
  // clock monitor reset request
  // ---------------------------------------------------------------
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      reset_req_ff <= 1'b0;
    end else begin
      reset_req_ff <= ext_clock_monitor_enable_ff && ext_clock_lost_i; // [RULE_01]
    end
  end

  // ---------------------------------------------------------------
  // interrupt status, enable and clear
  // ---------------------------------------------------------------
  logic [`IRQ_SRC_NUM-1:0] irq_event;
  assign irq_event[`IRQ_LOL]       = lose_lock;
  assign irq_event[`IRQ_LOCK_LOST] = lock_now && (nxt_lock_state != LOCK_HELD);

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      irq_status_ff <= '0;
      irq_enable_ff <= '0;
    end else begin
      irq_status_ff <= irq_event | (irq_status_ff & ~(wr_irq_clr ? wdata_i[`IRQ_SRC_NUM-1:0] : '0));
      if (wr_irq_en) begin
        irq_enable_ff <= wdata_i[`IRQ_SRC_NUM-1:0];
      end
    end
  end

  // ---------------------------------------------------------------
  // read data
  // ---------------------------------------------------------------
  logic [DATA_W-1:0] trim_rd;
  logic [DATA_W-1:0] status_rd;
  logic [DATA_W-1:0] rd_mux;

  assign trim_rd = {loss_of_lock_irq_enable_ff, 1'b0, ext_clock_monitor_enable_ff,
                    4'h0, slow_ref_fine_trim_ff} & `MON_TRIM_WMASK; // [RULE_03]
  assign status_rd = {loss_of_lock_flag_ff, lock_now, 1'b0, sif.ref_src_sync, // [RULE_09] [RULE_12] [RULE_13]
                      sif.mode_sync, 2'h0}; // [RULE_14]

  always_comb begin
    if (hit(addr_i, `ADDR_MON_TRIM)) begin
      rd_mux = trim_rd;
    end else if (hit(addr_i, `ADDR_STATUS)) begin
      rd_mux = status_rd;
    end else if (hit(addr_i, `ADDR_IRQ_STATUS)) begin
      rd_mux = DATA_W'(irq_status_ff);
    end else if (hit(addr_i, `ADDR_IRQ_ENABLE)) begin
      rd_mux = DATA_W'(irq_enable_ff);
    end else begin
      rd_mux = '0;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      rdata_ff <= '0;
    end else begin
      rdata_ff <= rd_i ? rd_mux : '0;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign rdata_o                    = rdata_ff;
  assign slow_ref_fine_trim_o       = slow_ref_fine_trim_ff;
  assign ext_clock_monitor_enable_o = ext_clock_monitor_enable_ff;
  assign clock_reset_req_o          = reset_req_ff;
  assign loss_of_lock_irq_o         = loss_of_lock_flag_ff && loss_of_lock_irq_enable_ff; // [RULE_08] [RULE_15] [RULE_16]
  assign irq_o                      = |(irq_status_ff & irq_enable_ff);

endmodule : clock_source_monitor_status

/* logic/status_sync.sv */
// two-stage synchroniser for reference source and clock mode report
`timescale 1ns/10ps
`include "clock_source_defines.svh"
module status_sync
  import clock_source_pkg::*;
(
  // clock and reset
  input  wire logic mclk_i,
  input  wire logic resetn_i,
  // status carrier
  status_sync_if.syncer sif
);
  logic       ref_meta_ff;
  logic       ref_sync_ff;
  logic [1:0] mode_meta_ff;
  logic [1:0] mode_sync_ff;

  always_ff @(posedge mclk_i) begin
    if (!resetn_i) begin
      ref_meta_ff  <= `RST_REF_SRC;
      ref_sync_ff  <= `RST_REF_SRC;
      mode_meta_ff <= `RST_MODE;
      mode_sync_ff <= `RST_MODE;
    end else begin
      ref_meta_ff  <= sif.ref_src_raw;
      ref_sync_ff  <= ref_meta_ff;
      mode_meta_ff <= sif.mode_raw;
      mode_sync_ff <= mode_meta_ff;
    end
  end

  assign sif.ref_src_sync = ref_sync_ff;
  assign sif.mode_sync    = mode_sync_ff;
endmodule : status_sync

/* shared/clock_source_defines.svh */
// constants for the clock source monitor and status block
`ifndef CLOCK_SOURCE_DEFINES_SVH
`define CLOCK_SOURCE_DEFINES_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define ADDR_MON_TRIM    16'h303B
`define ADDR_STATUS      16'h303C
`define ADDR_IRQ_STATUS  16'h3040
`define ADDR_IRQ_ENABLE  16'h3041
`define ADDR_IRQ_CLEAR   16'h3042

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define BIT_LOL_IRQ_EN   7
`define BIT_EXT_MON_EN   5
`define BIT_FINE_TRIM    0
`define BIT_LOL_FLAG     7
`define BIT_LOCK         6
`define BIT_REF_SRC      4
`define BIT_MODE_HI      3
`define BIT_MODE_LO      2

// ---------------------------------------------------------------
// reset values and masks
// ---------------------------------------------------------------
`define MON_TRIM_WMASK   8'hA1
`define RST_REF_SRC      1'h1
`define RST_MODE         2'h0
`define RST_LOCK_CNT     8'h00
`define IRQ_SRC_NUM      2
`define IRQ_LOL          0
`define IRQ_LOCK_LOST    1

`endif

/* shared/clock_source_pkg.sv */
// types shared by the clock source status block
package clock_source_pkg;

  typedef enum logic [1:0] {
    MODE_LOOP     = 2'b00,
    MODE_BYP_INT  = 2'b01,
    MODE_BYP_EXT  = 2'b10,
    MODE_RESERVED = 2'b11
  } clock_mode_t;

  typedef enum logic [1:0] {
    LOCK_OFF      = 2'b00,
    LOCK_SEEK     = 2'b01,
    LOCK_HELD     = 2'b10
  } lock_state_t;

endpackage : clock_source_pkg

/* shared/status_sync_if.sv */
// carrier for the synchronised reference and mode report
`timescale 1ns/10ps
interface status_sync_if;
  logic       ref_src_raw;
  logic [1:0] mode_raw;
  logic       ref_src_sync;
  logic [1:0] mode_sync;
  modport producer (output ref_src_raw, output mode_raw, input ref_src_sync, input mode_sync);
  modport syncer   (input ref_src_raw, input mode_raw, output ref_src_sync, output mode_sync);
endinterface : status_sync_if

/* test/clock_source_monitor_status_checker.sv */
// assertions for the clock source monitor and status block
`timescale 1ns/10ps
`include "clock_source_defines.svh"
module clock_source_monitor_status_checker
  import clock_source_pkg::*;
#(
  parameter int ADDR_W = 16,
  parameter int DATA_W = 8
) (
  // all ports of the block
  input wire logic              mclk_i,
  input wire logic              resetn_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [DATA_W-1:0] wdata_i,
  input wire logic              wr_i,
  input wire logic              rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic              debug_active_i,
  input wire logic              factory_fine_trim_i,
  input wire logic              loop_enabled_i,
  input wire logic              loop_in_tolerance_i,
  input wire logic              lock_detect_en_i,
  input wire logic              ref_source_select_i,
  input wire logic [2:0]        ref_divider_i,
  input wire logic [7:0]        slow_ref_coarse_trim_i,
  input wire logic [1:0]        clock_mode_select_i,
  input wire logic              stop_entry_i,
  input wire logic              ext_clock_lost_i,
  input wire logic              slow_ref_fine_trim_o,
  input wire logic              ext_clock_monitor_enable_o,
  input wire logic              clock_reset_req_o,
  input wire logic              loss_of_lock_irq_o,
  input wire logic              irq_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (!resetn_i);
  wire       rd_st = rd_i && addr_i == `ADDR_STATUS;
  wire       wr_st = wr_i && addr_i == `ADDR_STATUS;
  wire       rd_mt = rd_i && addr_i == `ADDR_MON_TRIM;
  wire       wr_mt = wr_i && addr_i == `ADDR_MON_TRIM;
  wire [2:0] cfg   = {ref_source_select_i, clock_mode_select_i};
  logic [1:0] up_ff;
  // cycles since reset release, saturating
  always_ff @(posedge mclk_i) begin
    if (!resetn_i) up_ff <= 2'h0;
    else if (up_ff != 2'h3) up_ff <= up_ff + 2'h1;
  end
  stat_resv_a: assert property (rd_st |=> rdata_o[5] == 1'h0 && rdata_o[1:0] == 2'h0)
    else $error("reserved status bits read nonzero");
  trim_resv_a: assert property (rd_mt |=> (rdata_o & 8'h5E) == 8'h00)
    else $error("reserved trim bits read nonzero");
  trim_write_a: assert property (wr_mt |=> {ext_clock_monitor_enable_o, slow_ref_fine_trim_o} ==
    {$past(wdata_i[5]), $past(wdata_i[0])}) else $error("trim or monitor bit not written");
  trim_load_a: assert property ($rose(resetn_i) && !wr_i |=> slow_ref_fine_trim_o ==
    ($past(factory_fine_trim_i) && !$past(debug_active_i))) else $error("fine trim not loaded");
  mon_req_a: assert property (ext_clock_monitor_enable_o && ext_clock_lost_i |=> clock_reset_req_o)
    else $error("no reset request on lost clock");
  mon_quiet_a: assert property (!ext_clock_monitor_enable_o |=> !clock_reset_req_o)
    else $error("reset request with monitor off");
  lol_hold_a: assert property (loss_of_lock_irq_o && !wr_mt && !(wr_st && wdata_i[7]) |=> loss_of_lock_irq_o)
    else $error("loss of lock request dropped");
  lol_clear_a: assert property (wr_st && wdata_i[7] && !lock_detect_en_i |=> !loss_of_lock_irq_o)
    else $error("loss of lock flag not cleared");
  irq_hold_a: assert property (irq_o && !(wr_i && addr_i inside {`ADDR_IRQ_ENABLE, `ADDR_IRQ_CLEAR}) |=> irq_o)
    else $error("interrupt dropped without clear");
  lock_off_a: assert property (rd_st && !loop_enabled_i && !$past(loop_enabled_i) |=> !rdata_o[6])
    else $error("lock bit set with loop disabled");
  sync_rep_a: assert property ($stable(cfg) [*3] ##0 (rd_st && up_ff == 2'h3) |=>
    rdata_o[4:2] == $past(cfg)) else $error("source or mode status wrong");
  cover property (loss_of_lock_irq_o);
  cover property (clock_reset_req_o);
  cover property (rd_st ##1 rdata_o[6]);
endmodule : clock_source_monitor_status_checker

bind clock_source_monitor_status clock_source_monitor_status_checker #(.ADDR_W(ADDR_W), .DATA_W(DATA_W)) u_checker (
  .mclk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .debug_active_i, .factory_fine_trim_i,
  .loop_enabled_i, .loop_in_tolerance_i, .lock_detect_en_i, .ref_source_select_i, .ref_divider_i,
  .slow_ref_coarse_trim_i, .clock_mode_select_i, .stop_entry_i, .ext_clock_lost_i, .slow_ref_fine_trim_o,
  .ext_clock_monitor_enable_o, .clock_reset_req_o, .loss_of_lock_irq_o, .irq_o);

/* test/clock_source_monitor_status_tb_top.sv */
// self-checking testbench for the clock source monitor and status block
`timescale 1ns/10ps
`include "clock_source_defines.svh"
module clock_source_monitor_status_tb_top;
  typedef struct packed {logic w; logic [15:0] a; logic [7:0] d;} row_t;
  logic        mclk_i, resetn_i, wr_i, rd_i, debug_active_i, factory_fine_trim_i, loop_enabled_i;
  logic        loop_in_tolerance_i, lock_detect_en_i, ref_source_select_i, stop_entry_i, ext_clock_lost_i;
  logic        slow_ref_fine_trim_o, ext_clock_monitor_enable_o, clock_reset_req_o, loss_of_lock_irq_o, irq_o;
  logic [15:0] addr_i;
  logic [7:0]  wdata_i, rdata_o, slow_ref_coarse_trim_i, v;
  logic [2:0]  ref_divider_i;
  logic [1:0]  clock_mode_select_i;
  int          error_cnt, total_checks;
  row_t        rows [15] = '{
    {1'h1, `ADDR_MON_TRIM, 8'hDF}, {1'h0, `ADDR_MON_TRIM, 8'h81}, {1'h1, `ADDR_MON_TRIM, 8'h5E},
    {1'h0, `ADDR_MON_TRIM, 8'h00}, {1'h1, `ADDR_MON_TRIM, 8'h01}, {1'h0, `ADDR_MON_TRIM, 8'h01},
    {1'h1, `ADDR_STATUS, 8'h7F}, {1'h0, `ADDR_STATUS, 8'h10}, {1'h1, `ADDR_IRQ_STATUS, 8'hFF},
    {1'h0, `ADDR_IRQ_STATUS, 8'h00}, {1'h1, `ADDR_IRQ_ENABLE, 8'h03}, {1'h0, `ADDR_IRQ_ENABLE, 8'h03},
    {1'h0, `ADDR_IRQ_CLEAR, 8'h00}, {1'h1, 16'h1234, 8'hFF}, {1'h0, 16'h1234, 8'h00}};

  clock_source_monitor_status #(.ADDR_W(16), .DATA_W(8)) DUT (
    .mclk_i, .resetn_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .debug_active_i, .factory_fine_trim_i,
    .loop_enabled_i, .loop_in_tolerance_i, .lock_detect_en_i, .ref_source_select_i, .ref_divider_i,
    .slow_ref_coarse_trim_i, .clock_mode_select_i, .stop_entry_i, .ext_clock_lost_i, .slow_ref_fine_trim_o,
    .ext_clock_monitor_enable_o, .clock_reset_req_o, .loss_of_lock_irq_o, .irq_o);

  always #2.5 mclk_i = ~mclk_i;

  task e(input int n);
    repeat (n) @(posedge mclk_i);
  endtask : e
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic pin(ref logic s, input logic x);
    @(negedge mclk_i);
    chk(8'(s), 8'(x));
  endtask : pin
  task bus_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge mclk_i);
    addr_i  <= a;
    wdata_i <= d;
    wr_i    <= 1'h1;
    @(posedge mclk_i);
    wr_i <= 1'h0;
  endtask : bus_wr
  task bus_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i   <= 1'h1;
    @(posedge mclk_i);
    rd_i <= 1'h0;
    @(negedge mclk_i);
    d = rdata_o;
  endtask : bus_rd
  task do_reset();
    @(posedge mclk_i);
    resetn_i <= 1'h0;
    e(12);
    resetn_i <= 1'h1;
  endtask : do_reset
  task stop_test();
    $display("checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : stop_test

  initial begin
    #20000;
    error_cnt++;
    stop_test();
  end

  initial begin
    {mclk_i, resetn_i, wr_i, rd_i, debug_active_i, loop_enabled_i, loop_in_tolerance_i, lock_detect_en_i} = '0;
    {stop_entry_i, ext_clock_lost_i, addr_i, wdata_i, ref_divider_i, slow_ref_coarse_trim_i} = '0;
    {clock_mode_select_i, factory_fine_trim_i, ref_source_select_i} = 4'h3;
    do_reset();
    bus_rd(`ADDR_MON_TRIM, v);
    chk(v, 8'h01);
    pin(slow_ref_fine_trim_o, 1'h1);
    foreach (rows[i]) begin
      if (rows[i].w) bus_wr(rows[i].a, rows[i].d);
      else begin
        bus_rd(rows[i].a, v);
        chk(v, rows[i].d);
      end
    end
    ref_source_select_i <= 1'h0;
    bus_wr(`ADDR_MON_TRIM, 8'h20);
    ext_clock_lost_i <= 1'h1;
    e(2);
    pin(clock_reset_req_o, 1'h1);
    pin(ext_clock_monitor_enable_o, 1'h1);
    bus_wr(`ADDR_MON_TRIM, 8'h80);
    ref_source_select_i <= 1'h1;
    e(2);
    pin(clock_reset_req_o, 1'h0);
    bus_wr(`ADDR_IRQ_ENABLE, 8'h01);
    {loop_enabled_i, loop_in_tolerance_i, lock_detect_en_i} <= 3'h7;
    e(4);
    bus_rd(`ADDR_STATUS, v);
    chk(v, 8'h50);
    for (int k = 0; k < 4; k++) begin
      e(1);
      case (k)
        0: ref_divider_i <= ref_divider_i + 3'h1;
        1: slow_ref_coarse_trim_i <= slow_ref_coarse_trim_i + 8'h01;
        2: stop_entry_i <= 1'h1;
        default: ref_source_select_i <= 1'h0;
      endcase
      bus_rd(`ADDR_STATUS, v);
      chk(v, 8'h10);
      e(1);
      {stop_entry_i, lock_detect_en_i} <= 2'h1;
      e(5);
      bus_rd(`ADDR_STATUS, v);
      chk(v, k == 3 ? 8'h40 : 8'h50);
    end
    for (int m = 2; m >= 0; m--) begin
      e(1);
      clock_mode_select_i <= 2'(m);
      e(4);
      bus_rd(`ADDR_STATUS, v);
      chk(v, 8'h40 | 8'(m << 2));
    end
    e(1);
    loop_in_tolerance_i <= 1'h0;
    e(2);
    pin(loss_of_lock_irq_o, 1'h1);
    pin(irq_o, 1'h1);
    bus_rd(`ADDR_STATUS, v);
    chk(v, 8'h80);
    bus_rd(`ADDR_IRQ_STATUS, v);
    chk(v, 8'h03);
    bus_wr(`ADDR_STATUS, 8'h7F);
    pin(loss_of_lock_irq_o, 1'h1);
    bus_wr(`ADDR_MON_TRIM, 8'h00);
    pin(loss_of_lock_irq_o, 1'h0);
    bus_wr(`ADDR_MON_TRIM, 8'h80);
    pin(loss_of_lock_irq_o, 1'h1);
    bus_wr(`ADDR_IRQ_ENABLE, 8'h00);
    pin(irq_o, 1'h0);
    bus_wr(`ADDR_IRQ_ENABLE, 8'h01);
    lock_detect_en_i <= 1'h0;
    pin(irq_o, 1'h1);
    bus_wr(`ADDR_STATUS, 8'h80);
    pin(loss_of_lock_irq_o, 1'h0);
    bus_wr(`ADDR_IRQ_CLEAR, 8'h03);
    {loop_enabled_i, loop_in_tolerance_i, lock_detect_en_i} <= 3'h3;
    pin(irq_o, 1'h0);
    e(3);
    bus_rd(`ADDR_STATUS, v);
    chk(v, 8'h00);
    e(1);
    {loop_enabled_i, ref_source_select_i} <= 2'h3;
    e(5);
    {loop_in_tolerance_i, debug_active_i} <= 2'h1;
    e(2);
    pin(loss_of_lock_irq_o, 1'h1);
    do_reset();
    bus_rd(`ADDR_STATUS, v);
    chk(v, 8'h10);
    bus_rd(`ADDR_MON_TRIM, v);
    chk(v, 8'h00);
    stop_test();
  end
endmodule : clock_source_monitor_status_tb_top
